/* dwi_regs.vh */
// Constants for the dual wiper two-wire write slave.
// Assumes inclusion by bare name from the design files of this block.
// Function
// - Each channel holds an 8-bit tap code selecting one of 256 taps.
// - Channel A and B codes live in separate, independently written registers.
// - A written tap code reaches its wiper output at once.
// - Reset sets both tap codes to midscale 80h.
// - Clock is input only; data line is only ever pulled low.
// - Transfer is start, address with direction, command, data, stop.
// - Idle bus is high; start is data falling while clock high.
// - Stop is data rising while clock high; bus becomes free.
// - One bit per clock pulse; data stable while clock is high.
// - Nine pulses per byte; receiver holds data low on the ninth.
// - Eighth address bit low means write, high means no-operation; no read.
// - Device never returns data; direction high moves nothing from device.
// - Upper four address bits are 0101; respond only on a match.
// - Low three address bits equal the three straps, MSB first.
// - Data byte loads the register chosen by the preceding command byte.
// - Command 11h loads channel A, command 12h loads channel B.
// - Command 13h loads both channels with the same byte.
// - Code 00h is nearest low terminal, FFh nearest high, linear between.
`ifndef DWI_REGS_VH
`define DWI_REGS_VH
`define DWI_TAP_RESET 8'h80
`define DWI_ADDR_FIXED 4'h5
`define DWI_CMD_A 8'h11
`define DWI_CMD_B 8'h12
`define DWI_CMD_AB 8'h13
`define DWI_BIT_LAST 4'h7
`define DWI_BIT_ACK 4'h8
`define DWI_BIT_ZERO 4'h0
`define DWI_BYTE_ADDR 2'h0
`define DWI_BYTE_CMD 2'h1
`define DWI_BYTE_DATA 2'h2
`define DWI_BYTE_EXTRA 2'h3
`endif

/* dwi_sync.v */
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/100ps
module dwi_sync (
  input wire clk,
  input wire arst_n,
  input wire d,
  output reg q
);
  reg meta;
  // Idle level is high so a reset does not fake a start or stop on the lines.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // dwi_sync

/* dwi_tap_regs.v */
// Two tap-code registers with independent load strobes; both strobes at once load both.
// Assumes load strobes are single-cycle pulses on clk.
`timescale 1ns/100ps
`include "dwi_regs.vh"
module dwi_tap_regs (
  input wire clk,
  input wire arst_n,
  input wire load_a,
  input wire load_b,
  input wire [7:0] data,
  output reg [7:0] tap_a,
  output reg [7:0] tap_b
);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tap_a <= `DWI_TAP_RESET;
      tap_b <= `DWI_TAP_RESET;
    end else begin
      if (load_a) begin
        tap_a <= data;
      end
      if (load_b) begin
        tap_b <= data;
      end
    end
  end
endmodule // dwi_tap_regs

/* dwi_slave.v */
// Top of the dual wiper two-wire write slave: bus decoding and tap outputs.
// Assumes SCL and SDA come from pins asynchronous to CLK, SCL far slower than CLK,
// and straps held steady; an external wire resolves SDA from the enable.
`timescale 1ns/100ps
`include "dwi_regs.vh"
module dwi_slave (
  input wire CLK,
  input wire ARST_N,
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output reg SDA_OE,
  input wire ADDR_STRAP_BIT0,
  input wire ADDR_STRAP_BIT1,
  input wire ADDR_STRAP_BIT2,
  output wire [7:0] WIPER_CHAN_A,
  output wire [7:0] WIPER_CHAN_B
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RECV = 3'b010;
  localparam ST_SKIP = 3'b100;

  wire scl;
  wire sda;
  reg scl_d;
  reg sda_d;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] bit_cnt;
  reg [1:0] byte_idx;
  reg [7:0] shift;
  reg [7:0] cmd;
  reg [2:0] strap;
  reg ack_pend;
  reg load_a;
  reg load_b;
  reg [7:0] load_data;

  dwi_sync u_sync_scl (
    .clk(CLK),
    .arst_n(ARST_N),
    .d(SCL_IN),
    .q(scl)
  );

  dwi_sync u_sync_sda (
    .clk(CLK),
    .arst_n(ARST_N),
    .d(SDA_IN),
    .q(sda)
  );

  dwi_tap_regs u_taps (
    .clk(CLK),
    .arst_n(ARST_N),
    .load_a(load_a),
    .load_b(load_b),
    .data(load_data),
    .tap_a(WIPER_CHAN_A),
    .tap_b(WIPER_CHAN_B)
  );

  // The line is only ever pulled low; no read path exists to drive data out.
  assign SDA_OUT = 1'b0;

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_det = scl & scl_d & sda_d & ~sda;
  wire stop_det = scl & scl_d & ~sda_d & sda;
  wire [7:0] rx_byte = {shift[6:0], sda};
  wire addr_ok = (rx_byte[7:4] == `DWI_ADDR_FIXED)
    && (rx_byte[3:1] == strap);
  wire is_write = ~rx_byte[0];

  // Straps are sampled by a clocked process so reset itself takes constants only.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap <= 3'h0;
    end else begin
      strap <= {ADDR_STRAP_BIT2, ADDR_STRAP_BIT1, ADDR_STRAP_BIT0};
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_RECV: begin
        next_state = ST_RECV;
      end
      ST_SKIP: begin
        next_state = ST_SKIP;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (start_det) begin
      next_state = ST_RECV;
    end else if (stop_det) begin
      next_state = ST_IDLE;
    end else if (state == ST_RECV && scl_rise && bit_cnt == `DWI_BIT_LAST) begin
      if (byte_idx == `DWI_BYTE_ADDR && !(addr_ok && is_write)) begin
        next_state = ST_SKIP;
      end
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      bit_cnt <= `DWI_BIT_ZERO;
      byte_idx <= `DWI_BYTE_ADDR;
      shift <= 8'h00;
      cmd <= 8'h00;
      ack_pend <= 1'b0;
      SDA_OE <= 1'b0;
      load_a <= 1'b0;
      load_b <= 1'b0;
      load_data <= 8'h00;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      state <= next_state;
      load_a <= 1'b0;
      load_b <= 1'b0;
      if (start_det || stop_det) begin
        bit_cnt <= `DWI_BIT_ZERO;
        byte_idx <= `DWI_BYTE_ADDR;
        ack_pend <= 1'b0;
        SDA_OE <= 1'b0;
      end else if (state == ST_RECV) begin
        if (scl_rise) begin
          if (bit_cnt == `DWI_BIT_ACK) begin
            bit_cnt <= `DWI_BIT_ZERO;
            // Index saturates so trailing bytes never reach the load decode.
            if (byte_idx != `DWI_BYTE_EXTRA) begin
              byte_idx <= byte_idx + 2'h1;
            end
          end else begin
            shift <= rx_byte;
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (bit_cnt == `DWI_BIT_LAST) begin
            // Acknowledge is armed now and applied on the next falling edge so
            // the line never changes while the clock is high.
            ack_pend <= (byte_idx != `DWI_BYTE_ADDR) || (addr_ok && is_write);
            if (byte_idx == `DWI_BYTE_CMD) begin
              cmd <= rx_byte;
            end
            if (byte_idx == `DWI_BYTE_DATA) begin
              load_data <= rx_byte;
              load_a <= (cmd == `DWI_CMD_A)
                || (cmd == `DWI_CMD_AB);
              load_b <= (cmd == `DWI_CMD_B)
                || (cmd == `DWI_CMD_AB);
            end
          end
        end
        if (scl_fall) begin
          SDA_OE <= ack_pend;
          ack_pend <= 1'b0;
        end
      end else begin
        SDA_OE <= 1'b0;
        ack_pend <= 1'b0;
      end
    end
  end
endmodule // dwi_slave

/* dwi_slave_assertions.sv */
// Port checker for the dual wiper slave.
// Assumes it is bound to dwi_slave.
`timescale 1ns/100ps
module dwi_slave_assertions (
  input wire CLK,
  input wire ARST_N,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire ADDR_STRAP_BIT0,
  input wire ADDR_STRAP_BIT1,
  input wire ADDR_STRAP_BIT2,
  input wire [7:0] WIPER_CHAN_A,
  input wire [7:0] WIPER_CHAN_B
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_pull_only: assert property (SDA_OUT == 1'b0) else $error("data driven high");
  a_reset_mid: assert property ($rose(ARST_N) |-> WIPER_CHAN_A == 8'h80
    && WIPER_CHAN_B == 8'h80) else $error("no midscale after reset");
  a_ack_in_low: assert property ($rose(SDA_OE) |-> !SCL_IN) else $error("ack during clock high");
  a_ack_length: assert property ($rose(SDA_OE) |-> SDA_OE[*4] ##[1:12] !SDA_OE)
    else $error("ack length wrong");
  a_ack_hold: assert property (SDA_OE && SCL_IN |=> SDA_OE) else $error("ack dropped early");
  a_joint_same: assert property ($changed(WIPER_CHAN_A) && $changed(WIPER_CHAN_B)
    |-> WIPER_CHAN_A == WIPER_CHAN_B) else $error("joint load differs");
  a_load_quiet: assert property ($changed(WIPER_CHAN_A) |-> !SDA_OE) else $error("load in ack");
  a_tap_stands: assert property ($changed(WIPER_CHAN_A) |=> $stable(WIPER_CHAN_A)[*4])
    else $error("tap not held");
  c_ack: cover property ($rose(SDA_OE));
  c_load_a: cover property ($changed(WIPER_CHAN_A));
  c_joint: cover property ($changed(WIPER_CHAN_A) && $changed(WIPER_CHAN_B));
endmodule // dwi_slave_assertions
bind dwi_slave dwi_slave_assertions u_dwi_slave_assertions (.*);

/* dwi_master_model.sv */
// Bus master model for the two-wire link.
// Assumes a pull-up on data; the clock stands high between frames.
`timescale 1ns/100ps
module dwi_master_model (
  output logic scl,
  output logic sda,
  input wire logic sda_bus
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Sends n bytes of w from the top, MSB first, and records each acknowledge.
  task automatic send(input logic [31:0] w, input int n, output logic [3:0] acks);
    acks = 4'h0;
    sda = 1'b0;
    #400;
    for (int j = 0; j < 9 * n; j++) begin
      scl = 1'b0;
      #200;
      sda = (j % 9 == 8) ? 1'b1 : w[31 - 8 * (j / 9) - j % 9];
      #200;
      scl = 1'b1;
      #200;
      if (j % 9 == 8) acks[3 - j / 9] = ~sda_bus;
      #200;
    end
    scl = 1'b0;
    #200;
    sda = 1'b0;
    #200;
    scl = 1'b1;
    #200;
    sda = 1'b1;
    #400;
  endtask
endmodule // dwi_master_model

/* dwi_slave_bench.sv */
// Self-checking bench for the dual wiper slave.
// Assumes the master model and the bound checker.
`timescale 1ns/100ps
module dwi_slave_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] strap = 3'h6;
  logic scl, sda_m, oe, out;
  logic [7:0] wa, wb;
  logic [3:0] acks;
  wire sda_bus = (oe ? out : 1'b1) & sda_m;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  // Frame, byte count, acknowledges, then expected taps of A and B.
  logic [55:0] rows [8] = '{56'h5C113C00_3_E_3C80, 56'h5C120000_3_E_3C00,
    56'h5C13FF00_3_E_FFFF, 56'h5C145500_3_E_FFFF, 56'h5C1101AA_4_F_01FF,
    56'h56117700_3_0_01FF, 56'h4C117700_3_0_01FF, 56'h5D117700_3_0_01FF};
  always #50 clk = ~clk;
  dwi_slave u_dwi_slave (.CLK(clk), .ARST_N(arst_n), .SCL_IN(scl), .SDA_IN(sda_bus),
    .SDA_OUT(out), .SDA_OE(oe), .ADDR_STRAP_BIT0(strap[0]), .ADDR_STRAP_BIT1(strap[1]),
    .ADDR_STRAP_BIT2(strap[2]), .WIPER_CHAN_A(wa), .WIPER_CHAN_B(wb));
  dwi_master_model u_dwi_master_model (.scl(scl), .sda(sda_m), .sda_bus(sda_bus));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #5 arst_n = 1'b1;
    chk("wiper a", 8'h80, wa);
    chk("wiper b", 8'h80, wb);
    repeat (4) @(posedge clk);
    for (int r = 0; r < 8; r++) begin
      u_dwi_master_model.send(rows[r][55:24], int'(rows[r][23:20]), acks);
      repeat (10) @(posedge clk);
      #5;
      chk("acks", {4'h0, rows[r][19:16]}, {4'h0, acks});
      chk("wiper a", rows[r][15:8], wa);
      chk("wiper b", rows[r][7:0], wb);
    end
    // A reset after the last frame must bring both taps back to midscale.
    arst_n = 1'b0;
    @(posedge clk);
    #5 arst_n = 1'b1;
    chk("wiper a", 8'h80, wa);
    chk("wiper b", 8'h80, wb);
    stop_test;
  end
endmodule // dwi_slave_bench
